// File: hw/mwi_pkg.sv
// shared constants and channel types for the msi write ingress port
package mwi_pkg;
  localparam int          ID_W          = 8;
  localparam int          ADDR_W        = 40;
  localparam int          LEN_W         = 8;
  localparam int          DID_W         = 32;
  localparam int          EVT_W         = 32;
  localparam int          BASE_LSB      = 16;
  localparam logic [15:0] TRANSLATE_OFS = 16'h0040;
  localparam int          WIDE_BYTES    = 8;
  localparam int          WORD_BYTES    = 4;
  localparam int          HALF_BYTES    = 2;
  localparam int          RD_MAX_BYP    = 512;
  localparam int          WR_CAP_BYP    = 256;
  localparam int          RD_MAX_DIR    = 1;
  localparam int          CNT_W         = 9;
  localparam int          RC_W          = 10;
  localparam int          STAT_CNT_W    = 16;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // apb register map
  localparam logic [11:0] REG_CTRL      = 12'h000;
  localparam logic [11:0] REG_STAT      = 12'h004;
  localparam logic [11:0] REG_LDID      = 12'h008;
  localparam int          CTRL_EN_BIT   = 0;
  localparam logic        CTRL_EN_RST   = 1'h1;

  typedef struct packed {
    logic [ID_W-1:0]   id;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0]  len;
    logic [DID_W-1:0]  user;
    logic [5:0]        atop;
    logic [3:0]        snoop;
  } mwi_aw_t;

  typedef struct packed {
    logic [ID_W-1:0]   id;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0]  len;
  } mwi_ar_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [1:0]      resp;
  } mwi_b_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [1:0]      resp;
    logic            last;
  } mwi_r_t;

  typedef struct packed {
    logic [DID_W-1:0] dev;
    logic [EVT_W-1:0] evt;
  } mwi_msi_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FWDA  = 3'h1,
    ST_FWDW  = 3'h2,
    ST_LDAT  = 3'h3,
    ST_DRAIN = 3'h4,
    ST_RESP  = 3'h5
  } mwi_wst_t;
endpackage : mwi_pkg

// File: hw/mwi_strobe_chk.sv
// byte strobe shape check: contiguity, size and alignment
`timescale 1ns/100ps
module mwi_strobe_chk #(
  parameter int NB = 8
) (
  // strobe and low address bits
  input  logic [NB-1:0]         wstrb,
  input  logic [$clog2(NB)-1:0] addr_lo,
  // result
  output logic                  ok,
  output logic [$clog2(NB):0]   nbytes,
  output logic [$clog2(NB)-1:0] lo
);
  localparam int          LW  = $clog2(NB);
  localparam int          CW  = LW + 1;
  localparam logic [NB:0] ONE = (NB+1)'(1);

  logic          found;
  logic [NB:0]   mask;
  logic [CW-1:0] nm1;

  always_comb begin
    found  = 1'b0;
    lo     = '0;
    nbytes = '0;
    for (int i = NB - 1; i >= 0; i--) begin
      if (wstrb[i]) begin
        found  = 1'b1;
        lo     = LW'(i);
        nbytes = nbytes + CW'(1);
      end
    end
    nm1  = nbytes - CW'(1);
    mask = ((ONE << nbytes) - ONE) << lo;
    // size comes from the strobes alone, never from the declared size
    ok   = found && ((nbytes & nm1) == '0) && (wstrb == mask[NB-1:0]) &&
           ((lo & nm1[LW-1:0]) == '0) && (lo == addr_lo);
  end
endmodule : mwi_strobe_chk

// File: hw/mwi_msi_slot.sv
// one waiting-msi slot of the ordering tracker
`timescale 1ns/100ps
module mwi_msi_slot
  import mwi_pkg::*;
#(
  parameter int CW = CNT_W
) (
  // clock and reset
  input  logic          pclk,
  input  logic          presetn,
  // load and drain
  input  logic          alloc,
  input  mwi_msi_t      alloc_msi,
  input  logic [CW-1:0] alloc_wait,
  input  logic          dn_done,
  input  logic          take,
  // state
  output logic          busy,
  output logic          ready,
  output mwi_msi_t      msi
);
  logic          busy_r, busy_nxt;
  logic [CW-1:0] wait_r, wait_nxt;
  mwi_msi_t      msi_r,  msi_nxt;

  always_comb begin
    busy_nxt = busy_r;
    wait_nxt = wait_r;
    msi_nxt  = msi_r;
    if (take) begin
      busy_nxt = 1'b0;
    end
    // each downstream completion retires one earlier forwarded write
    if (busy_r && dn_done && wait_r != '0) begin
      wait_nxt = wait_r - CW'(1);
    end
    if (alloc) begin
      busy_nxt = 1'b1;
      msi_nxt  = alloc_msi;
      wait_nxt = (dn_done && alloc_wait != '0) ? alloc_wait - CW'(1) : alloc_wait;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      wait_r <= '0;
      msi_r  <= '0;
    end else begin
      busy_r <= busy_nxt;
      wait_r <= wait_nxt;
      msi_r  <= msi_nxt;
    end
  end

  assign busy  = busy_r;
  assign ready = busy_r && (wait_r == '0);
  assign msi   = msi_r;

  chk_slot_waits: assert property (@(posedge pclk) disable iff (!presetn)
    (alloc && alloc_wait > CW'(1)) |=> !ready)
    else $error("msi slot released before its prerequisites completed");
endmodule : mwi_msi_slot

// File: hw/mwi_ingress_port.sv
// msi write ingress port: subordinate write port, bypass forwarding and ordering tracker
//------------------------------------------------------------------
// Function
// - data path width is 64, 128, 256 or 512 bits, fixed at build.
// - outstanding reads go to one destination at a time only.
// - with bypass, only base-address matches reach the service; rest forwarded.
// - without bypass, address bits 16 and up are ignored; system decodes.
// - attributes ignored except to spot atomics and cache maintenance, answered legally.
// - access size is taken from the byte strobes, not the size field.
// - strobes not one aligned contiguous block cause rejection.
// - wide encapsulation: identifier in upper 32 bits, single-beat 64-bit writes only.
// - sideband mode: identifier on write-address user, single-beat 32/16-bit writes only.
// - one identifier transport per instance, chosen at build.
// - a direct stream msi input may sit beside or replace this port.
// - with bypass, each msi waits for earlier forwarded writes to complete.
// - two sized buffers: forwarded writes in flight and waiting msis.
// - with bypass: 512 reads outstanding, writes limited to 256 at most.
// - combined acceptance is read plus write; without bypass 1 read, 2 writes.
// - a port shared with the distributor shows the distributor's properties.
//------------------------------------------------------------------
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module mwi_ingress_port
  import mwi_pkg::*;
#(
  parameter int   DW            = 64,
  parameter logic BYPASS        = 1'b0,
  parameter logic WIDE_MODE     = 1'b0,
  parameter int   BYP_MAX_OUT   = 16,
  parameter int   BYP_INT_COUNT = 4
) (
  // clock and reset
  input  logic                       pclk,
  input  logic                       presetn,
  // static base address of the service
  input  logic [ADDR_W-1:BASE_LSB]   target_base,
  // upstream write channels
  input  logic                       s_awvalid,
  output logic                       s_awready,
  input  mwi_aw_t                    s_aw,
  input  logic                       s_wvalid,
  output logic                       s_wready,
  input  logic [DW-1:0]              s_wdata,
  input  logic [DW/8-1:0]            s_wstrb,
  input  logic                       s_wlast,
  output logic                       s_bvalid,
  input  logic                       s_bready,
  output mwi_b_t                     s_b,
  // upstream read channels
  input  logic                       s_arvalid,
  output logic                       s_arready,
  input  mwi_ar_t                    s_ar,
  output logic                       s_rvalid,
  input  logic                       s_rready,
  output mwi_r_t                     s_r,
  output logic [DW-1:0]              s_rdata,
  // downstream forwarded channels
  output logic                       m_awvalid,
  input  logic                       m_awready,
  output mwi_aw_t                    m_aw,
  output logic                       m_wvalid,
  input  logic                       m_wready,
  output logic [DW-1:0]              m_wdata,
  output logic [DW/8-1:0]            m_wstrb,
  output logic                       m_wlast,
  input  logic                       m_bvalid,
  output logic                       m_bready,
  input  mwi_b_t                     m_b,
  output logic                       m_arvalid,
  input  logic                       m_arready,
  output mwi_ar_t                    m_ar,
  input  logic                       m_rvalid,
  output logic                       m_rready,
  input  mwi_r_t                     m_r,
  input  logic [DW-1:0]              m_rdata,
  // direct stream msi input
  input  logic                       d_valid,
  output logic                       d_ready,
  input  mwi_msi_t                   d_msi,
  // msi out to translation
  output logic                       msi_valid,
  input  logic                       msi_ready,
  output mwi_msi_t                   msi,
  // apb register slave
  input  logic                       psel,
  input  logic                       penable,
  input  logic                       pwrite,
  input  logic [11:0]                paddr,
  input  logic [31:0]                pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr
);
  localparam int             NB     = DW / 8;
  localparam int             LW     = $clog2(NB);
  localparam int             INT_N  = BYPASS ? BYP_INT_COUNT : 1;
  localparam int             IW     = (INT_N > 1) ? $clog2(INT_N) : 1;
  localparam logic [CNT_W-1:0] WR_LIM = CNT_W'((BYP_MAX_OUT > WR_CAP_BYP) ? WR_CAP_BYP : BYP_MAX_OUT);
  localparam logic [RC_W-1:0]  RD_LIM = RC_W'(BYPASS ? RD_MAX_BYP : RD_MAX_DIR);

  //------------------------------------------------------------------
  // write path
  //------------------------------------------------------------------
  mwi_wst_t          st_r, st_nxt;
  mwi_aw_t           aw_r, aw_nxt;
  logic              err_r, err_nxt;
  mwi_msi_t          msi_r, msi_nxt;
  logic [CNT_W-1:0]  wr_cnt_r, wr_cnt_nxt;
  logic              lb_valid_r, lb_valid_nxt;
  mwi_b_t            lb_r, lb_nxt;
  logic              aw_fwd, aw_nonmem, lb_take, lb_set, alloc, dn_done, slot_free, msi_good, size_ok;
  logic              sc_ok;
  logic [LW:0]       sc_n;
  logic [LW-1:0]     sc_lo;
  logic [DW-1:0]     sh;
  logic              ctrl_en_r;

  mwi_strobe_chk #(.NB(NB)) u_strobe (
    .wstrb   (s_wstrb),
    .addr_lo (aw_r.addr[LW-1:0]),
    .ok      (sc_ok),
    .nbytes  (sc_n),
    .lo      (sc_lo)
  );

  assign aw_fwd    = BYPASS && (s_aw.addr[ADDR_W-1:BASE_LSB] != target_base);
  assign aw_nonmem = (s_aw.atop != '0) || (s_aw.snoop != '0);
  assign size_ok   = WIDE_MODE ? (sc_n == (LW+1)'(WIDE_BYTES)) :
                     ((sc_n == (LW+1)'(WORD_BYTES)) || (sc_n == (LW+1)'(HALF_BYTES)));
  // only the low offset is decoded; upper bits belong to the system decoder
  assign msi_good  = sc_ok && size_ok && (aw_r.addr[BASE_LSB-1:0] == TRANSLATE_OFS) && ctrl_en_r;
  assign sh        = s_wdata >> {sc_lo, 3'h0};
  assign lb_take   = lb_valid_r && s_bready;
  assign dn_done   = BYPASS && m_bvalid && m_bready;

  always_comb begin
    st_nxt    = st_r;
    aw_nxt    = aw_r;
    err_nxt   = err_r;
    msi_nxt   = msi_r;
    s_awready = 1'b0;
    s_wready  = 1'b0;
    m_awvalid = 1'b0;
    m_wvalid  = 1'b0;
    alloc     = 1'b0;
    lb_set    = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        s_awready = !aw_fwd || (wr_cnt_r < WR_LIM);
        if (s_awvalid && s_awready) begin
          aw_nxt = s_aw;
          err_nxt = 1'b1;
          if (aw_fwd) begin
            st_nxt = ST_FWDA;
          end else if (aw_nonmem || s_aw.len != '0) begin
            st_nxt = ST_DRAIN;
          end else begin
            st_nxt  = ST_LDAT;
            err_nxt = 1'b0;
          end
        end
      end
      ST_FWDA: begin
        m_awvalid = 1'b1;
        if (m_awready) begin
          st_nxt = ST_FWDW;
        end
      end
      ST_FWDW: begin
        m_wvalid = s_wvalid;
        s_wready = m_wready;
        if (s_wvalid && m_wready && s_wlast) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_LDAT: begin
        s_wready = 1'b1;
        if (s_wvalid) begin
          err_nxt     = !msi_good || !s_wlast;
          msi_nxt.evt = (!WIDE_MODE && sc_n == (LW+1)'(HALF_BYTES)) ? {16'h0000, sh[15:0]} : sh[EVT_W-1:0];
          msi_nxt.dev = WIDE_MODE ? sh[EVT_W+DID_W-1:EVT_W] : aw_r.user;
          st_nxt      = s_wlast ? ST_RESP : ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        s_wready = 1'b1;
        if (s_wvalid && s_wlast) begin
          st_nxt = ST_RESP;
        end
      end
      ST_RESP: begin
        // a good msi needs a free slot; a rejected one only needs the response register
        if ((!lb_valid_r || lb_take) && (err_r || slot_free)) begin
          lb_set = 1'b1;
          alloc  = !err_r;
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_comb begin
    wr_cnt_nxt   = wr_cnt_r + CNT_W'(m_awvalid && m_awready) - CNT_W'(dn_done);
    lb_valid_nxt = lb_valid_r;
    lb_nxt       = lb_r;
    if (lb_take) begin
      lb_valid_nxt = 1'b0;
    end
    if (lb_set) begin
      lb_valid_nxt = 1'b1;
      lb_nxt.id    = aw_r.id;
      lb_nxt.resp  = err_r ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r       <= ST_IDLE;
      aw_r       <= '0;
      err_r      <= 1'b0;
      msi_r      <= '0;
      wr_cnt_r   <= '0;
      lb_valid_r <= 1'b0;
      lb_r       <= '0;
    end else begin
      st_r       <= st_nxt;
      aw_r       <= aw_nxt;
      err_r      <= err_nxt;
      msi_r      <= msi_nxt;
      wr_cnt_r   <= wr_cnt_nxt;
      lb_valid_r <= lb_valid_nxt;
      lb_r       <= lb_nxt;
    end
  end

  // local responses win the b channel so they cannot starve behind forwarded traffic
  assign s_bvalid = lb_valid_r || (BYPASS && m_bvalid);
  assign s_b      = lb_valid_r ? lb_r : m_b;
  assign m_bready = s_bready && !lb_valid_r;
  assign m_aw     = aw_r;
  assign m_wdata  = s_wdata;
  assign m_wstrb  = s_wstrb;
  assign m_wlast  = s_wlast;

  //------------------------------------------------------------------
  // ordering tracker slots and msi output
  //------------------------------------------------------------------
  logic [INT_N-1:0] busy, rdy;
  mwi_msi_t         slot_msi [INT_N];
  logic [IW-1:0]    alloc_idx, rel_idx;
  logic             rel_any;

  always_comb begin
    slot_free = 1'b0;
    alloc_idx = '0;
    rel_any   = 1'b0;
    rel_idx   = '0;
    for (int i = INT_N - 1; i >= 0; i--) begin
      if (!busy[i]) begin
        slot_free = 1'b1;
        alloc_idx = IW'(i);
      end
      if (rdy[i]) begin
        rel_any = 1'b1;
        rel_idx = IW'(i);
      end
    end
  end

  for (genvar g = 0; g < INT_N; g++) begin : g_slot
    mwi_msi_slot #(.CW(CNT_W)) u_slot (
      .pclk       (pclk),
      .presetn    (presetn),
      .alloc      (alloc && alloc_idx == IW'(g)),
      .alloc_msi  (msi_r),
      .alloc_wait (wr_cnt_r),
      .dn_done    (dn_done),
      .take       (msi_ready && rel_any && rel_idx == IW'(g)),
      .busy       (busy[g]),
      .ready      (rdy[g]),
      .msi        (slot_msi[g])
    );
  end

  // the direct stream input shares the output behind the tracker
  assign msi_valid = rel_any || d_valid;
  assign msi       = rel_any ? slot_msi[rel_idx] : d_msi;
  assign d_ready   = msi_ready && !rel_any;

  //------------------------------------------------------------------
  // read path
  //------------------------------------------------------------------
  logic [RC_W-1:0]  rd_cnt_r, rd_cnt_nxt;
  logic             rd_dst_r, rd_dst_nxt;
  logic             lr_busy_r, lr_busy_nxt;
  logic [ID_W-1:0]  lr_id_r, lr_id_nxt;
  logic [LEN_W-1:0] lr_left_r, lr_left_nxt;
  logic             ar_local, rd_same, r_done, ar_hs;

  assign ar_local  = !BYPASS || (s_ar.addr[ADDR_W-1:BASE_LSB] == target_base);
  assign rd_same   = (rd_cnt_r == '0) || (rd_dst_r == ar_local);
  assign s_arready = rd_same && (rd_cnt_r < RD_LIM) && (ar_local ? !lr_busy_r : m_arready);
  assign m_arvalid = BYPASS && s_arvalid && !ar_local && rd_same && (rd_cnt_r < RD_LIM);
  assign m_ar      = s_ar;
  assign ar_hs     = s_arvalid && s_arready;
  // write-only register: local reads return zero with okay
  assign s_rvalid  = rd_dst_r ? lr_busy_r : (BYPASS && m_rvalid);
  assign s_r       = rd_dst_r ? mwi_r_t'{id: lr_id_r, resp: RESP_OKAY, last: (lr_left_r == '0)} : m_r;
  assign s_rdata   = rd_dst_r ? '0 : m_rdata;
  assign m_rready  = s_rready && !rd_dst_r;
  assign r_done    = s_rvalid && s_rready && s_r.last;

  always_comb begin
    rd_cnt_nxt  = rd_cnt_r + RC_W'(ar_hs) - RC_W'(r_done);
    rd_dst_nxt  = ar_hs ? ar_local : rd_dst_r;
    lr_busy_nxt = lr_busy_r;
    lr_id_nxt   = lr_id_r;
    lr_left_nxt = lr_left_r;
    if (rd_dst_r && lr_busy_r && s_rready) begin
      lr_busy_nxt = (lr_left_r != '0);
      lr_left_nxt = lr_left_r - LEN_W'(lr_left_r != '0);
    end
    if (ar_hs && ar_local) begin
      lr_busy_nxt = 1'b1;
      lr_id_nxt   = s_ar.id;
      lr_left_nxt = s_ar.len;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_cnt_r  <= '0;
      rd_dst_r  <= 1'b1;
      lr_busy_r <= 1'b0;
      lr_id_r   <= '0;
      lr_left_r <= '0;
    end else begin
      rd_cnt_r  <= rd_cnt_nxt;
      rd_dst_r  <= rd_dst_nxt;
      lr_busy_r <= lr_busy_nxt;
      lr_id_r   <= lr_id_nxt;
      lr_left_r <= lr_left_nxt;
    end
  end

  //------------------------------------------------------------------
  // apb registers
  //------------------------------------------------------------------
  logic                  ctrl_en_nxt;
  logic [STAT_CNT_W-1:0] acc_r, acc_nxt, rej_r, rej_nxt;
  logic [DID_W-1:0]      ldid_r, ldid_nxt;
  logic                  hit_c, hit_s, hit_l, apb_acc;

  assign apb_acc = psel && penable;
  assign hit_c   = (paddr == REG_CTRL);
  assign hit_s   = (paddr == REG_STAT);
  assign hit_l   = (paddr == REG_LDID);
  assign pready  = 1'b1;
  assign pslverr = apb_acc && !(hit_c || (!pwrite && (hit_s || hit_l)));
  assign prdata  = (!psel || pwrite) ? 32'h0000_0000 :
                   hit_c ? {31'h0000_0000, ctrl_en_r} :
                   hit_s ? {rej_r, acc_r} :
                   hit_l ? ldid_r : 32'h0000_0000;

  always_comb begin
    ctrl_en_nxt = (apb_acc && pwrite && hit_c) ? pwdata[CTRL_EN_BIT] : ctrl_en_r;
    acc_nxt     = acc_r + STAT_CNT_W'(lb_set && !err_r);
    rej_nxt     = rej_r + STAT_CNT_W'(lb_set && err_r);
    ldid_nxt    = alloc ? msi_r.dev : ldid_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_r <= CTRL_EN_RST;
      acc_r     <= '0;
      rej_r     <= '0;
      ldid_r    <= '0;
    end else begin
      ctrl_en_r <= ctrl_en_nxt;
      acc_r     <= acc_nxt;
      rej_r     <= rej_nxt;
      ldid_r    <= ldid_nxt;
    end
  end

  //------------------------------------------------------------------
  // checks
  //------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_rd_one_dest: assert property (ar_hs && rd_cnt_r != '0 |-> ar_local == rd_dst_r)
    else $error("read accepted to a second destination");
  chk_fwd_unmatched: assert property (st_r == ST_FWDA |-> BYPASS && aw_r.addr[ADDR_W-1:BASE_LSB] != target_base)
    else $error("matching address forwarded downstream");
  chk_no_fwd_direct: assert property (!BYPASS |-> !m_awvalid && !m_arvalid)
    else $error("forwarding without bypass");
  chk_nonmem_drain: assert property (st_r == ST_IDLE && s_awvalid && s_awready && !aw_fwd && aw_nonmem
    |=> st_r == ST_DRAIN && err_r)
    else $error("non-memory write not rejected");
  chk_strobe_reject: assert property (st_r == ST_LDAT && s_wvalid && !sc_ok |=> err_r)
    else $error("bad strobe pattern accepted");
  chk_err_resp: assert property (st_r == ST_RESP && lb_set && err_r
    |=> lb_valid_r && lb_r.resp == RESP_SLVERR && $stable(acc_r))
    else $error("rejected write without error response");
  chk_wr_limit: assert property (wr_cnt_r <= WR_LIM)
    else $error("forwarded writes over limit");
  chk_rd_limit: assert property (rd_cnt_r <= RD_LIM)
    else $error("outstanding reads over limit");
  chk_msi_size: assert property (alloc |-> $past(size_ok, 1) || $past(st_r, 1) == ST_RESP)
    else $error("msi accepted with wrong size");
endmodule : mwi_ingress_port

// File: testbench/mwi_mgr_model.sv
// manager model issuing one write at a time on the subordinate port
`timescale 1ns/100ps
module mwi_mgr_model
  import mwi_pkg::*;
(
  // clock
  input  logic        pclk,
  // write channels
  output logic        s_awvalid,
  input  logic        s_awready,
  output mwi_aw_t     s_aw,
  output logic        s_wvalid,
  input  logic        s_wready,
  output logic [63:0] s_wdata,
  output logic [7:0]  s_wstrb,
  output logic        s_wlast,
  input  logic        s_bvalid,
  output logic        s_bready,
  input  mwi_b_t      s_b
);
  initial {s_awvalid, s_wvalid, s_bready, s_wlast, s_aw, s_wdata, s_wstrb} = '0;
  // wake copy comes from a flop so a gated clock never restarts on a glitch
  logic awake_r = 1'b0;
  always @(posedge pclk) awake_r <= s_awvalid;
  // released address and write data are inverted so a stale value never passes for a live one
  task automatic wr(input mwi_aw_t a, input logic [63:0] d, input logic [7:0] s, output mwi_b_t r);
    s_awvalid <= 1'b1;
    s_aw <= a;
    do @(posedge pclk); while (s_awready !== 1'b1);
    s_awvalid <= 1'b0;
    s_aw <= ~a;
    for (int i = 0; i <= a.len; i++) begin
      s_wvalid <= 1'b1;
      s_wdata <= d;
      s_wstrb <= s;
      s_wlast <= (i == a.len);
      do @(posedge pclk); while (s_wready !== 1'b1);
    end
    s_wvalid <= 1'b0;
    s_wdata <= ~d;
    s_bready <= 1'b1;
    do @(posedge pclk); while (s_bvalid !== 1'b1);
    r = s_b;
    s_bready <= 1'b0;
  endtask : wr
endmodule : mwi_mgr_model

// File: testbench/mwi_ingress_port_tb.sv
// self-checking bench: msi writes, apb registers, local reads, direct msis
`timescale 1ns/100ps
module mwi_ingress_port_tb;
  import mwi_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        d_valid = 0, s_arvalid = 0, s_rready = 1, msi_ready = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, ldev = '0;
  logic        m_bvalid = 0, m_rvalid = 0, m_arready = 0;
  logic [ADDR_W-1:BASE_LSB] target_base = '0;
  mwi_msi_t    d_msi = '0, msi, got;
  mwi_ar_t     s_ar = '0;
  mwi_aw_t     s_aw;
  mwi_b_t      s_b;
  mwi_r_t      s_r;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_wlast, s_bvalid, s_bready, s_arready, s_rvalid;
  logic        d_ready, msi_valid, pready, pslverr;
  logic [63:0] s_wdata, s_rdata;
  logic [7:0]  s_wstrb;
  int          mismatches = 0, checked = 0, ngot = 0, cyc = 0, acc = 0, rej = 0;

  always #10 pclk = ~pclk;

  // base tie-off and downstream returns toggle at random: without bypass the port must ignore them
  mwi_ingress_port DUT (.*, .m_awready(1'b0), .m_wready(1'b0), .m_b('0), .m_r('0), .m_rdata('0), .m_awvalid(),
    .m_aw(), .m_wvalid(), .m_wdata(), .m_wstrb(), .m_wlast(), .m_bready(), .m_arvalid(), .m_ar(), .m_rready());
  mwi_mgr_model mgr (.*);

  // msi_ready stalls every other cycle so msi_valid must hold its value
  always @(posedge pclk) begin
    msi_ready <= ~msi_ready;
    {target_base, m_bvalid, m_rvalid, m_arready} <= 27'($urandom);
    cyc <= cyc + 1;
    if (msi_valid === 1'b1 && msi_ready === 1'b1) begin
      got <= msi;
      ngot <= ngot + 1;
    end
    if (cyc > 6000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic msi_wr(input logic [7:0] s, input logic [7:0] len, input logic [5:0] at, input logic [1:0] e);
    mwi_aw_t     a;
    logic [63:0] d;
    mwi_b_t      r;
    int          n0;
    a = '0;
    a.id = 8'($urandom);
    a.addr = {24'($urandom), 16'h0040};
    a.len = len;
    a.atop = at;
    a.user = $urandom;
    d = {$urandom, $urandom};
    n0 = ngot;
    mgr.wr(a, d, s, r);
    chk("bresp", {a.id, e}, r);
    for (int i = 0; i < 12 && ngot == n0; i++) @(posedge pclk);
    if (e === RESP_OKAY) begin
      acc++;
      ldev = a.user;
      chk("msi", {a.user, s == 8'h03 ? {16'h0, d[15:0]} : d[31:0]}, got);
    end else begin
      rej++;
      chk("msi count", n0, ngot);
    end
  endtask : msi_wr

  task results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  initial begin
    logic [31:0] r;
    logic        e;
    void'($urandom(82));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, REG_CTRL, '0, r, e);
    chk("ctrl reset", 32'h1, r);
    repeat (2) begin
      msi_wr(8'h0f, 8'h0, 6'h0, RESP_OKAY);
      msi_wr(8'h03, 8'h0, 6'h0, RESP_OKAY);
      msi_wr(8'h05, 8'h0, 6'h0, RESP_SLVERR);
      msi_wr(8'h06, 8'h0, 6'h0, RESP_SLVERR);
      msi_wr(8'hff, 8'h0, 6'h0, RESP_SLVERR);
      msi_wr(8'h0f, 8'h1, 6'h0, RESP_SLVERR);
      msi_wr(8'h0f, 8'h0, 6'h20, RESP_SLVERR);
    end
    apb(1'b1, REG_CTRL, '0, r, e);
    msi_wr(8'h0f, 8'h0, 6'h0, RESP_SLVERR);
    apb(1'b1, REG_CTRL, 32'h1, r, e);
    apb(1'b0, REG_STAT, '0, r, e);
    chk("stat", {16'(rej), 16'(acc)}, r);
    apb(1'b0, REG_LDID, '0, r, e);
    chk("last dev", ldev, r);
    apb(1'b0, 12'h00c, '0, r, e);
    chk("unmapped", 1'b1, e);
    s_arvalid <= 1'b1;
    s_ar <= '{id: 8'h05, addr: 40'h40, len: 8'h1};
    do @(posedge pclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      do @(posedge pclk); while (s_rvalid !== 1'b1);
      chk("rdata", '0, s_rdata);
      chk("rbeat", {8'h05, RESP_OKAY, 1'(b == 1)}, {s_r.id, s_r.resp, s_r.last});
    end
    d_msi <= {$urandom, $urandom};
    d_valid <= 1'b1;
    do @(posedge pclk); while (d_ready !== 1'b1);
    d_valid <= 1'b0;
    for (int i = 0; i < 12 && got !== d_msi; i++) @(posedge pclk);
    chk("direct msi", d_msi, got);
    results();
  end
endmodule : mwi_ingress_port_tb
